// [rtl/cntmw_core.sv]
// transceiver mode control, enable delay, wake detection and time-outs
// assumes chip mode from the state machine on the same clock; pins async
//
// Added by the designer: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "cntmw_regs.svh"
module cntmw_core #(
    parameter int EN_CYC       = `CNTMW_EN_CYC,
    parameter int WAKE_DOM_CYC = `CNTMW_WAKE_DOM_CYC,
    parameter int WAKE_GAP_CYC = `CNTMW_WAKE_GAP_CYC,
    parameter int TXD_TO_CYC   = `CNTMW_TXD_TO_CYC,
    parameter int BUS_TO_CYC   = `CNTMW_BUS_TO_CYC
) (
    // clock and reset
    input  wire logic                    ref_clk_in,
    input  wire logic                    rst_in,
    // register port
    input  wire cntmw_pkg::cntmw_bus_type bus_in,
    output logic [7:0]                   rdata_out,
    // chip state
    input  wire cntmw_pkg::cntmw_chip_type chip_mode_in,
    input  wire logic                    wd_enabled_in,
    output logic                         chip_restart_req_out,
    output logic                         wd_enable_req_out,
    output logic                         int_out,
    // controller pins
    input  wire logic                    tx_data_input,
    output logic                         rx_data_out,
    // bus side
    input  wire logic                    bus_dom_in,
    input  wire logic                    supply_uv_in,
    output logic                         drv_dom_out
);
    localparam int CW = 32;

    function automatic logic mode_ok(input cntmw_pkg::cntmw_mode_type m,
                                     input cntmw_pkg::cntmw_chip_type c);
        logic ns;
        ns = (c == cntmw_pkg::CNTMW_CHIP_NORMAL) || (c == cntmw_pkg::CNTMW_CHIP_STOP);
        if (m == cntmw_pkg::CNTMW_NORMAL || m == cntmw_pkg::CNTMW_RXONLY) begin
            mode_ok = ns;
        end else if (m == cntmw_pkg::CNTMW_WAKE) begin
            mode_ok = (c != cntmw_pkg::CNTMW_CHIP_FAILSAFE);
        end else begin
            mode_ok = 1'b1;
        end
    endfunction : mode_ok

    // synchronisers
    logic [1:0] tx_s, bus_s, uv_s;
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            tx_s  <= 2'b11;
            bus_s <= 2'b00;
            uv_s  <= 2'b00;
        end else begin
            tx_s  <= {tx_s[0], tx_data_input};
            bus_s <= {bus_s[0], bus_dom_in};
            uv_s  <= {uv_s[0], supply_uv_in};
        end
    end
    wire tx_q  = tx_s[1];
    wire bus_q = bus_s[1];
    wire uv_q  = uv_s[1];

    cntmw_pkg::cntmw_mode_type mode;
    cntmw_pkg::cntmw_chip_type chip_prev;
    logic          armed, woken, wake_flag, fault_flag, uv_flag, wd_on_wake;
    logic          en_done, tx_gate, tx_to;
    logic [CW-1:0] en_cnt, wk_cnt, txd_cnt, bus_cnt;
    cntmw_pkg::cntmw_wk_type wk_st;
    logic [7:0]    wake_stat;

    // register decode
    wire wr_mode = bus_in.wr && (bus_in.addr == `CNTMW_ADDR_MODE);
    wire wr_stat = bus_in.wr && (bus_in.addr == `CNTMW_ADDR_STATUS);
    wire wr_wks  = bus_in.wr && (bus_in.addr == `CNTMW_ADDR_WAKE_STAT);
    wire wr_cfg  = bus_in.wr && (bus_in.addr == `CNTMW_ADDR_CONFIG);
    wire cntmw_pkg::cntmw_mode_type req_mode = cntmw_pkg::cntmw_mode_type'(bus_in.wdata[1:0]);
    wire mode_accept = wr_mode && mode_ok(req_mode, chip_mode_in);
    wire chip_chg = chip_mode_in != chip_prev;
    wire enter_low = chip_chg && (chip_mode_in == cntmw_pkg::CNTMW_CHIP_STOP
                     || chip_mode_in == cntmw_pkg::CNTMW_CHIP_SLEEP
                     || chip_mode_in == cntmw_pkg::CNTMW_CHIP_FAILSAFE);
    wire force_wake = (chip_mode_in == cntmw_pkg::CNTMW_CHIP_FAILSAFE)
                      && (mode != cntmw_pkg::CNTMW_WAKE);
    wire is_normal = (mode == cntmw_pkg::CNTMW_NORMAL);

    // wake pattern detector
    wire wk_dom_done = wk_cnt >= CW'(WAKE_DOM_CYC);
    wire wk_gap_over = wk_cnt >= CW'(WAKE_GAP_CYC);
    logic wake_hit;
    cntmw_pkg::cntmw_wk_type next_wk_st;
    always_comb begin
        next_wk_st = wk_st;
        wake_hit   = 1'b0;
        case (wk_st)
            cntmw_pkg::CNTMW_WK_IDLE: if (bus_q) next_wk_st = cntmw_pkg::CNTMW_WK_DOM1;
            cntmw_pkg::CNTMW_WK_DOM1: begin
                if (!bus_q) begin
                    next_wk_st = wk_dom_done ? cntmw_pkg::CNTMW_WK_GAP : cntmw_pkg::CNTMW_WK_IDLE;
                end
            end
            cntmw_pkg::CNTMW_WK_GAP: begin
                if (bus_q) begin
                    next_wk_st = cntmw_pkg::CNTMW_WK_DOM2;
                end else if (wk_gap_over) begin
                    next_wk_st = cntmw_pkg::CNTMW_WK_IDLE;
                end
            end
            cntmw_pkg::CNTMW_WK_DOM2: begin
                if (!bus_q) begin
                    next_wk_st = cntmw_pkg::CNTMW_WK_IDLE;
                end else if (wk_dom_done) begin
                    wake_hit   = 1'b1;
                    next_wk_st = cntmw_pkg::CNTMW_WK_IDLE;
                end
            end
            default: next_wk_st = cntmw_pkg::CNTMW_WK_IDLE;
        endcase
    end
    wire wk_run = (mode == cntmw_pkg::CNTMW_WAKE) && armed;
    wire wake_evt = wk_run && wake_hit;
    wire st_chg = next_wk_st != wk_st;

    always_ff @(posedge ref_clk_in) begin
        if (rst_in || !wk_run) begin
            wk_st  <= cntmw_pkg::CNTMW_WK_IDLE;
            wk_cnt <= '0;
        end else begin
            wk_st  <= next_wk_st;
            wk_cnt <= st_chg ? '0 : (wk_dom_done && wk_gap_over ? wk_cnt : wk_cnt + 1'b1);
        end
    end

    // mode, arming and wake state
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            mode  <= cntmw_pkg::CNTMW_OFF;
            armed <= 1'b1;
            woken <= 1'b0;
        end else if (force_wake) begin
            mode  <= cntmw_pkg::CNTMW_WAKE;
            armed <= 1'b1;
            woken <= 1'b0;
        end else if (mode_accept && req_mode != mode) begin
            mode  <= req_mode;
            armed <= 1'b1;
            woken <= 1'b0;
        end else if (wake_evt) begin
            armed <= 1'b0;
            woken <= 1'b1;
        end else if (enter_low) begin
            armed <= 1'b1;
        end
    end

    // enable delay and time-outs
    wire en_cnt_done = en_cnt >= CW'(EN_CYC);
    wire txd_over = txd_cnt >= CW'(TXD_TO_CYC);
    wire bus_over = bus_cnt >= CW'(BUS_TO_CYC);
    always_ff @(posedge ref_clk_in) begin
        if (rst_in || !is_normal) begin
            en_cnt  <= '0;
            en_done <= 1'b0;
            tx_gate <= 1'b0;
        end else begin
            en_cnt  <= en_cnt_done ? en_cnt : en_cnt + 1'b1;
            en_done <= en_cnt_done;
            if (!en_done) begin
                tx_gate <= 1'b0;
            end else if (tx_q) begin
                tx_gate <= 1'b1;
            end
        end
    end
    always_ff @(posedge ref_clk_in) begin
        if (rst_in || !is_normal || tx_q) begin
            txd_cnt <= '0;
            tx_to   <= 1'b0;
        end else begin
            txd_cnt <= txd_over ? txd_cnt : txd_cnt + 1'b1;
            tx_to   <= tx_to | txd_over;
        end
    end
    always_ff @(posedge ref_clk_in) begin
        if (rst_in || !bus_q) begin
            bus_cnt <= '0;
        end else begin
            bus_cnt <= bus_over ? bus_cnt : bus_cnt + 1'b1;
        end
    end

    // flags: hardware set wins over software clear
    wire ev_fault = (is_normal && txd_over) || bus_over;
    wire ev_uv = is_normal && uv_q;
    wire quiet = (chip_mode_in == cntmw_pkg::CNTMW_CHIP_SLEEP)
                 || (chip_mode_in == cntmw_pkg::CNTMW_CHIP_RESTART)
                 || (chip_mode_in == cntmw_pkg::CNTMW_CHIP_FAILSAFE);
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            fault_flag <= 1'b0;
            uv_flag    <= 1'b0;
            wake_flag  <= 1'b0;
            wake_stat  <= 8'h00;
            wd_on_wake <= 1'b0;
        end else begin
            fault_flag <= ev_fault | (fault_flag & ~(wr_stat & bus_in.wdata[0]));
            uv_flag    <= ev_uv | (uv_flag & ~(wr_stat & bus_in.wdata[1]));
            wake_flag  <= wake_evt | (wake_flag & ~(wr_wks & bus_in.wdata[0]));
            wake_stat  <= wake_evt ? {5'h00, chip_mode_in} :
                          (wr_wks & bus_in.wdata[0]) ? 8'h00 : wake_stat;
            wd_on_wake <= wr_cfg ? bus_in.wdata[0] : wd_on_wake;
        end
    end

    // outputs
    wire drive = is_normal && tx_gate && !tx_to && !uv_q;
    logic [7:0] rd_mux;
    always_comb begin
        if (bus_in.addr == `CNTMW_ADDR_MODE) begin
            rd_mux = {6'h00, mode};
        end else if (bus_in.addr == `CNTMW_ADDR_STATUS) begin
            rd_mux = {5'h00, tx_to, uv_flag, fault_flag};
        end else if (bus_in.addr == `CNTMW_ADDR_WAKE_STAT) begin
            rd_mux = {wake_flag, wake_stat[6:0]};
        end else if (bus_in.addr == `CNTMW_ADDR_CONFIG) begin
            rd_mux = {7'h00, wd_on_wake};
        end else begin
            rd_mux = 8'h00;
        end
    end
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            rdata_out            <= 8'h00;
            drv_dom_out          <= 1'b0;
            rx_data_out          <= 1'b1;
            int_out              <= 1'b0;
            chip_restart_req_out <= 1'b0;
            wd_enable_req_out    <= 1'b0;
        end else begin
            rdata_out            <= bus_in.rd ? rd_mux : 8'h00;
            drv_dom_out          <= drive && !tx_q;
            rx_data_out          <= woken ? 1'b0 :
                                    ((is_normal || mode == cntmw_pkg::CNTMW_RXONLY) ? !bus_q : 1'b1);
            int_out              <= wake_evt && !quiet;
            chip_restart_req_out <= wake_evt && (chip_mode_in == cntmw_pkg::CNTMW_CHIP_SLEEP);
            wd_enable_req_out    <= wake_evt && wd_on_wake && !wd_enabled_in
                                    && (chip_mode_in == cntmw_pkg::CNTMW_CHIP_STOP);
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (rst_in) chip_prev <= cntmw_pkg::CNTMW_CHIP_NORMAL;
        else chip_prev <= chip_mode_in;
    end

    property p_off_after_reset;
        @(posedge ref_clk_in) rst_in |=> mode == cntmw_pkg::CNTMW_OFF;
    endproperty
    a_off_after_reset: assert property (p_off_after_reset) else $error("mode not off");
    property p_no_drive_off_mode;
        @(posedge ref_clk_in) disable iff (rst_in) !is_normal |=> !drv_dom_out;
    endproperty
    a_no_drive_off_mode: assert property (p_no_drive_off_mode) else $error("drive outside normal");
    property p_rx_low_woken;
        @(posedge ref_clk_in) disable iff (rst_in) woken |=> !rx_data_out;
    endproperty
    a_rx_low_woken: assert property (p_rx_low_woken) else $error("rx not low");
    property p_mode_stays;
        @(posedge ref_clk_in) disable iff (rst_in) wake_evt |=> mode == cntmw_pkg::CNTMW_WAKE;
    endproperty
    a_mode_stays: assert property (p_mode_stays) else $error("mode changed on wake");
    property p_no_rewake;
        @(posedge ref_clk_in) disable iff (rst_in) wake_evt |=> !wake_evt;
    endproperty
    a_no_rewake: assert property (p_no_rewake) else $error("double wake");
    property p_int_sleep;
        @(posedge ref_clk_in) disable iff (rst_in)
            (wake_evt && chip_mode_in == cntmw_pkg::CNTMW_CHIP_SLEEP) |=> !int_out && chip_restart_req_out;
    endproperty
    a_int_sleep: assert property (p_int_sleep) else $error("sleep wake wrong");
    property p_int_stop;
        @(posedge ref_clk_in) disable iff (rst_in)
            (wake_evt && chip_mode_in == cntmw_pkg::CNTMW_CHIP_STOP) |=> int_out;
    endproperty
    a_int_stop: assert property (p_int_stop) else $error("no interrupt");
    property p_txto_off;
        @(posedge ref_clk_in) disable iff (rst_in) tx_to |=> !drv_dom_out;
    endproperty
    a_txto_off: assert property (p_txto_off) else $error("drive in timeout");
    property p_enable_gate;
        @(posedge ref_clk_in) disable iff (rst_in) $rose(is_normal) |=> !drv_dom_out [*2];
    endproperty
    a_enable_gate: assert property (p_enable_gate) else $error("early drive");
    property p_uv_off;
        @(posedge ref_clk_in) disable iff (rst_in) uv_q |=> !drv_dom_out;
    endproperty
    a_uv_off: assert property (p_uv_off) else $error("drive in undervoltage");
    property p_rx_off;
        @(posedge ref_clk_in) disable iff (rst_in) mode == cntmw_pkg::CNTMW_OFF |=> rx_data_out;
    endproperty
    a_rx_off: assert property (p_rx_off) else $error("rx not idle while off");
    property p_refuse_normal;
        @(posedge ref_clk_in) disable iff (rst_in)
            (wr_mode && req_mode == cntmw_pkg::CNTMW_NORMAL
             && !is_normal
             && chip_mode_in == cntmw_pkg::CNTMW_CHIP_SLEEP)
            |=> !is_normal;
    endproperty
    a_refuse_normal: assert property (p_refuse_normal) else $error("normal in sleep");
    property p_refuse_rxonly;
        @(posedge ref_clk_in) disable iff (rst_in)
            (wr_mode && req_mode == cntmw_pkg::CNTMW_RXONLY
             && mode != cntmw_pkg::CNTMW_RXONLY
             && chip_mode_in == cntmw_pkg::CNTMW_CHIP_SLEEP)
            |=> mode != cntmw_pkg::CNTMW_RXONLY;
    endproperty
    a_refuse_rxonly: assert property (p_refuse_rxonly) else $error("rx-only in sleep");
    property p_failsafe_wake;
        @(posedge ref_clk_in) disable iff (rst_in)
            (chip_mode_in == cntmw_pkg::CNTMW_CHIP_FAILSAFE && !wr_mode)
            |=> mode == cntmw_pkg::CNTMW_WAKE;
    endproperty
    a_failsafe_wake: assert property (p_failsafe_wake) else $error("not forced");
    property p_wd_req;
        @(posedge ref_clk_in) disable iff (rst_in)
            (wake_evt && wd_on_wake && !wd_enabled_in
             && chip_mode_in == cntmw_pkg::CNTMW_CHIP_STOP) |=> wd_enable_req_out;
    endproperty
    a_wd_req: assert property (p_wd_req) else $error("no watchdog request");
    property p_no_wd_req;
        @(posedge ref_clk_in) disable iff (rst_in) wd_enabled_in |=> !wd_enable_req_out;
    endproperty
    a_no_wd_req: assert property (p_no_wd_req) else $error("watchdog already on");
    property p_bus_fault;
        @(posedge ref_clk_in) disable iff (rst_in) bus_over |=> fault_flag;
    endproperty
    a_bus_fault: assert property (p_bus_fault) else $error("bus fault not flagged");
    property p_txd_fault;
        @(posedge ref_clk_in) disable iff (rst_in) (is_normal && txd_over && !tx_q) |=> fault_flag && tx_to;
    endproperty
    a_txd_fault: assert property (p_txd_fault) else $error("tx timeout not flagged");
    property p_uv_flag;
        @(posedge ref_clk_in) disable iff (rst_in) ev_uv |=> uv_flag;
    endproperty
    a_uv_flag: assert property (p_uv_flag) else $error("undervoltage not flagged");
    property p_rdata_idle;
        @(posedge ref_clk_in) disable iff (rst_in) !bus_in.rd |=> rdata_out == 8'h00;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data not idle");
    property p_rearm;
        @(posedge ref_clk_in) disable iff (rst_in) (enter_low && !wake_evt) |=> armed;
    endproperty
    a_rearm: assert property (p_rearm) else $error("not rearmed");
    c_sleep_wake: cover property (@(posedge ref_clk_in) chip_restart_req_out);
    c_wake: cover property (@(posedge ref_clk_in) wake_evt);
    c_drive: cover property (@(posedge ref_clk_in) drv_dom_out);
    c_txto: cover property (@(posedge ref_clk_in) $rose(tx_to));
endmodule : cntmw_core
`default_nettype wire

// [rtl/cntmw_pkg.sv]
// types of the transceiver mode and wake control block
// assumes the constants header is included by users
package cntmw_pkg;
    typedef enum logic [1:0] {
        CNTMW_OFF     = 2'b00,
        CNTMW_WAKE    = 2'b01,
        CNTMW_RXONLY  = 2'b10,
        CNTMW_NORMAL  = 2'b11
    } cntmw_mode_type;
    typedef enum logic [2:0] {
        CNTMW_CHIP_NORMAL   = 3'b000,
        CNTMW_CHIP_STOP     = 3'b001,
        CNTMW_CHIP_SLEEP    = 3'b010,
        CNTMW_CHIP_RESTART  = 3'b011,
        CNTMW_CHIP_FAILSAFE = 3'b100
    } cntmw_chip_type;
    typedef enum logic [1:0] {
        CNTMW_WK_IDLE  = 2'b00,
        CNTMW_WK_DOM1  = 2'b01,
        CNTMW_WK_GAP   = 2'b10,
        CNTMW_WK_DOM2  = 2'b11
    } cntmw_wk_type;
    typedef struct packed {
        logic [3:0]  addr;
        logic [7:0]  wdata;
        logic        wr;
        logic        rd;
    } cntmw_bus_type;
endpackage : cntmw_pkg

// [rtl/cntmw_regs.svh]
// constants of the transceiver mode and wake control block
// assumes a 125 MHz core clock and a single clock domain
// Overview of operation
// - normal mode carries data up to 2 Mbaud
// - mode chosen by software mode bits
// - off after reset; wake ignored while off
// - normal mode only in chip normal/stop
// - tx low dominant; rx mirrors bus in normal and receive-only
// - low tx at enable end not sent
// - receive-only: driver off, chip normal/stop only
// - wake-capable allowed widely; forced in fail-safe
// - wake needs dominant, short recessive, dominant
// - rx held low after wake until mode change
// - mode reads 01; no rewake until rearm
// - mode toggle rearms, flag clear not needed
// - chip stop/sleep/fail-safe entry rearms
// - wake in stop/normal: interrupt, status, rx low
// - stop wake enables watchdog if configured
// - sleep wake goes restart then normal
// - sleep wake raises no interrupt
// - tx dominant timeout: driver off, fault flag
// - driver returns when tx released
// - bus dominant timeout sets fault flag
// - supply undervoltage in normal disables driver
`ifndef CNTMW_REGS_SVH
`define CNTMW_REGS_SVH
`define CNTMW_ADDR_MODE       4'h0
`define CNTMW_ADDR_STATUS     4'h1
`define CNTMW_ADDR_WAKE_STAT  4'h2
`define CNTMW_ADDR_CONFIG     4'h3
`define CNTMW_CLK_MHZ         125
`define CNTMW_EN_DELAY_US     10
`define CNTMW_WAKE_DOM_US     1
`define CNTMW_WAKE_GAP_US     1000
`define CNTMW_TXD_TO_US       2000
`define CNTMW_BUS_TO_US       2000
`define CNTMW_EN_CYC          (`CNTMW_EN_DELAY_US * `CNTMW_CLK_MHZ)
`define CNTMW_WAKE_DOM_CYC    (`CNTMW_WAKE_DOM_US * `CNTMW_CLK_MHZ)
`define CNTMW_WAKE_GAP_CYC    (`CNTMW_WAKE_GAP_US * `CNTMW_CLK_MHZ)
`define CNTMW_TXD_TO_CYC      (`CNTMW_TXD_TO_US * `CNTMW_CLK_MHZ)
`define CNTMW_BUS_TO_CYC      (`CNTMW_BUS_TO_US * `CNTMW_CLK_MHZ)
`endif

// [test/cntmw_ctrl_model.sv]
// controller-side model that drives the transmit pin
// assumes start_in pulses once normal mode has been written
`timescale 1ns/1ps
`default_nettype none
module cntmw_ctrl_model #(
    parameter int EN_CYC = 8
) (
    // clock and reset
    input  wire logic ref_clk_in,
    input  wire logic rst_in,
    // bench requests
    input  wire logic start_in,
    input  wire logic dom_req_in,
    input  wire logic early_in,
    // controller pin
    output logic      tx_data_out
);
    int   cnt;
    logic ready;
    always_ff @(posedge ref_clk_in) begin
        if (rst_in || start_in) begin
            cnt <= 0;
        end else if (cnt < EN_CYC + 4) begin
            cnt <= cnt + 1;
        end
    end
    assign ready = (cnt >= EN_CYC + 4);
    // recessive until enable delay is over, unless told to misbehave
    assign tx_data_out = ready ? !dom_req_in : !(dom_req_in && early_in);
endmodule : cntmw_ctrl_model
`default_nettype wire

// [test/testbench.sv]
// self-checking bench of the transceiver mode and wake control core
// assumes the core, its package and the controller model are compiled first
`timescale 1ns/1ps
`default_nettype none
module testbench;
    localparam int EN_CYC = 8;
    logic                       ref_clk_in;
    logic                       rst_in;
    cntmw_pkg::cntmw_bus_type   bus;
    cntmw_pkg::cntmw_chip_type  chip;
    logic [7:0]                 rdata;
    logic                       wd_en, restart_req, wd_req, irq, tx, rx, drv;
    logic                       ext_dom, uv, start, dom_req, early;
    int                         error_cnt, checks, cyc, int_cnt, wd_cnt, rs_cnt;
    wire logic                  bus_dom = drv | ext_dom;

    cntmw_core #(.EN_CYC(EN_CYC), .WAKE_DOM_CYC(4), .WAKE_GAP_CYC(20), .TXD_TO_CYC(50),
        .BUS_TO_CYC(50)) dut_u (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .bus_in(bus),
        .rdata_out(rdata), .chip_mode_in(chip), .wd_enabled_in(wd_en),
        .chip_restart_req_out(restart_req), .wd_enable_req_out(wd_req), .int_out(irq),
        .tx_data_input(tx), .rx_data_out(rx), .bus_dom_in(bus_dom), .supply_uv_in(uv),
        .drv_dom_out(drv));
    cntmw_ctrl_model #(.EN_CYC(EN_CYC)) ctrl_u (.ref_clk_in(ref_clk_in), .rst_in(rst_in),
        .start_in(start), .dom_req_in(dom_req), .early_in(early), .tx_data_out(tx));

    initial begin
        ref_clk_in = 1'b0;
        forever #4 ref_clk_in = ~ref_clk_in;
    end

    // cycle ceiling and pulse counters
    always @(posedge ref_clk_in) begin
        cyc++;
        if (irq === 1'b1) int_cnt++;
        if (wd_req === 1'b1) wd_cnt++;
        if (restart_req === 1'b1) rs_cnt++;
        if (cyc == 6000) begin
            error_cnt++;
            end_of_test();
        end
    end

    task automatic end_of_test;
        if (error_cnt == 0 && checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : end_of_test

    task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_reg

    task automatic chk_pin(ref logic got, input logic exp);
        @(negedge ref_clk_in);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
        @(posedge ref_clk_in);
    endtask : chk_pin

    task automatic w(input int n);
        repeat (n) @(posedge ref_clk_in);
    endtask : w

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge ref_clk_in);
        bus.addr <= a;
        bus.wdata <= d;
        bus.wr <= 1'b1;
        @(posedge ref_clk_in);
        bus.wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [3:0] a, input logic [7:0] m, input logic [7:0] e);
        @(posedge ref_clk_in);
        bus.addr <= a;
        bus.rd <= 1'b1;
        @(posedge ref_clk_in);
        bus.rd <= 1'b0;
        @(negedge ref_clk_in);
        chk_reg(rdata & m, e);
        @(posedge ref_clk_in);
    endtask : rd

    task automatic go_normal;
        wr(4'h0, 8'h03);
        start <= 1'b1;
        @(posedge ref_clk_in);
        start <= 1'b0;
        w(EN_CYC + 6);
    endtask : go_normal

    // dominant, short recessive gap, dominant
    task automatic wake_pat;
        @(posedge ref_clk_in);
        ext_dom <= 1'b1;
        w(8);
        ext_dom <= 1'b0;
        w(6);
        ext_dom <= 1'b1;
        w(8);
        ext_dom <= 1'b0;
        w(10);
    endtask : wake_pat

    initial begin
        bus = '0;
        chip = cntmw_pkg::CNTMW_CHIP_NORMAL;
        {wd_en, ext_dom, uv, start, dom_req, early} = '0;
        rst_in = 1'b1;
        w(6);
        rst_in <= 1'b0;
        rd(4'h0, 8'hff, 8'h00);
        rd(4'h7, 8'hff, 8'h00);
        chk_pin(rx, 1'b1);
        chip <= cntmw_pkg::CNTMW_CHIP_SLEEP;
        wr(4'h0, 8'h03);
        rd(4'h0, 8'hff, 8'h00);
        wr(4'h0, 8'h02);
        rd(4'h0, 8'hff, 8'h00);
        chip <= cntmw_pkg::CNTMW_CHIP_NORMAL;
        wake_pat();
        chk_reg(8'(int_cnt), 8'h00);
        go_normal();
        rd(4'h0, 8'hff, 8'h03);
        dom_req <= 1'b1;
        w(6);
        chk_pin(drv, 1'b1);
        chk_pin(rx, 1'b0);
        dom_req <= 1'b0;
        w(6);
        chk_pin(rx, 1'b1);
        wr(4'h1, 8'h03);
        dom_req <= 1'b1;
        w(70);
        chk_pin(drv, 1'b0);
        rd(4'h1, 8'h05, 8'h05);
        dom_req <= 1'b0;
        w(6);
        rd(4'h1, 8'h04, 8'h00);
        rd(4'h0, 8'hff, 8'h03);
        dom_req <= 1'b1;
        w(6);
        chk_pin(drv, 1'b1);
        dom_req <= 1'b0;
        uv <= 1'b1;
        w(4);
        dom_req <= 1'b1;
        w(6);
        chk_pin(drv, 1'b0);
        rd(4'h1, 8'h02, 8'h02);
        dom_req <= 1'b0;
        uv <= 1'b0;
        w(4);
        dom_req <= 1'b1;
        w(6);
        chk_pin(drv, 1'b1);
        wr(4'h0, 8'h00);
        early <= 1'b1;
        go_normal();
        w(6);
        chk_pin(drv, 1'b0);
        dom_req <= 1'b0;
        w(4);
        dom_req <= 1'b1;
        w(6);
        chk_pin(drv, 1'b1);
        early <= 1'b0;
        wr(4'h0, 8'h02);
        w(6);
        chk_pin(drv, 1'b0);
        ext_dom <= 1'b1;
        w(6);
        chk_pin(rx, 1'b0);
        ext_dom <= 1'b0;
        dom_req <= 1'b0;
        wr(4'h0, 8'h01);
        wr(4'h2, 8'h01);
        wake_pat();
        chk_reg(8'(int_cnt), 8'h01);
        chk_pin(rx, 1'b0);
        rd(4'h0, 8'hff, 8'h01);
        rd(4'h2, 8'h87, 8'h80);
        wake_pat();
        chk_reg(8'(int_cnt), 8'h01);
        wr(4'h0, 8'h00);
        w(6);
        chk_pin(rx, 1'b1);
        wr(4'h0, 8'h01);
        wake_pat();
        chk_reg(8'(int_cnt), 8'h02);
        wr(4'h3, 8'h01);
        chip <= cntmw_pkg::CNTMW_CHIP_STOP;
        w(4);
        wake_pat();
        chk_reg(8'(wd_cnt), 8'h01);
        chk_reg(8'(int_cnt), 8'h03);
        rd(4'h2, 8'h87, 8'h81);
        wd_en <= 1'b1;
        wr(4'h0, 8'h00);
        wr(4'h0, 8'h01);
        wake_pat();
        chk_reg(8'(wd_cnt), 8'h01);
        chk_reg(8'(int_cnt), 8'h04);
        chip <= cntmw_pkg::CNTMW_CHIP_SLEEP;
        w(4);
        wake_pat();
        chk_reg(8'(rs_cnt), 8'h01);
        chk_reg(8'(int_cnt), 8'h04);
        chk_pin(rx, 1'b0);
        wr(4'h0, 8'h00);
        chip <= cntmw_pkg::CNTMW_CHIP_FAILSAFE;
        w(4);
        rd(4'h0, 8'hff, 8'h01);
        chip <= cntmw_pkg::CNTMW_CHIP_NORMAL;
        wr(4'h0, 8'h00);
        wr(4'h1, 8'h03);
        ext_dom <= 1'b1;
        w(60);
        ext_dom <= 1'b0;
        rd(4'h1, 8'h01, 8'h01);
        rd(4'h0, 8'hff, 8'h00);
        end_of_test();
    end
endmodule : testbench
`default_nettype wire
